// ### mpc_pkg.sv
package mpc_pkg;
    // operating configurations and output modes
    typedef enum logic [2:0] {
        MPC_PRESET1, MPC_PRESET2, MPC_TOTAL, MPC_BATCH, MPC_DUAL, MPC_TWIN
    } mpc_cfg_t;
    typedef enum logic [1:0] {MPC_HOLD, MPC_INSTANT, MPC_ONESHOT} mpc_omode_t;
    // value widths and full-scale limits
    localparam int VW = 20;
    localparam int SW = 22;
    localparam logic [19:0] FS_SIX = 20'hF423F;
    localparam logic [19:0] FS_FOUR = 20'h0270F;
    localparam logic [20:0] NEG_SIX = 21'h1869F;
    localparam logic [20:0] NEG_FOUR = 21'h003E7;
    // one-shot duration in 10 ms units
    localparam logic [13:0] SHOT_MIN = 14'h0001;
    localparam logic [13:0] SHOT_MAX = 14'h270F;
    // timing, rate 40 MHz
    localparam int CLK_HZ = 40_000_000;
    localparam int SHOT_UNIT_MS = 10;
    localparam int TICK_CYC = CLK_HZ / 1000 * SHOT_UNIT_MS;
    localparam int WIDTH_SLOW_US = 16700;
    localparam int WIDTH_FAST_US = 100;
    localparam int FILT_SLOW = CLK_HZ / 1_000_000 * WIDTH_SLOW_US / 2;
    localparam int FILT_FAST = CLK_HZ / 1_000_000 * WIDTH_FAST_US / 2;
endpackage

// ### mpc_in_filter.sv
`timescale 1ns/1ps
`default_nettype none
module mpc_in_filter #(
    parameter int SLOW = mpc_pkg::FILT_SLOW,
    parameter int FAST = mpc_pkg::FILT_FAST
) (
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic pin_in,
    input wire logic fast_in,
    output logic level_out,
    output logic rise_out
);
    logic s1, s2, lvl, rise;
    logic [19:0] cnt;
    logic next_lvl, next_rise;
    logic [19:0] next_cnt, lim;

    // level accepted only after staying changed for the filter length
    always_comb begin
        lim = fast_in ? 20'(FAST - 1) : 20'(SLOW - 1);
        next_lvl = lvl;
        next_rise = 1'b0;
        next_cnt = 20'h00000;
        if (s2 != lvl) begin
            if (cnt >= lim) begin
                next_lvl = s2;
                next_rise = s2;
            end else begin
                next_cnt = cnt + 20'h00001;
            end
        end
    end

    // two-stage synchroniser then filter state
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            lvl <= 1'b0;
            rise <= 1'b0;
            cnt <= 20'h00000;
        end else begin
            s1 <= pin_in;
            s2 <= s1;
            lvl <= next_lvl;
            rise <= next_rise;
            cnt <= next_cnt;
        end
    end

    assign level_out = lvl;
    assign rise_out = rise;
endmodule
`default_nettype wire

// ### mpc_pulse_timer.sv
`timescale 1ns/1ps
`default_nettype none
module mpc_pulse_timer #(
    parameter int TICK = mpc_pkg::TICK_CYC
) (
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic start_in,
    input wire logic stop_in,
    input wire logic [13:0] units_in,
    output logic active_out
);
    logic act;
    logic [18:0] tick;
    logic [13:0] left;
    logic next_act;
    logic [18:0] next_tick;
    logic [13:0] next_left;

    // stop wins, then start reloads the full duration
    always_comb begin
        next_act = act;
        next_tick = tick;
        next_left = left;
        if (stop_in) begin
            next_act = 1'b0;
        end else if (start_in) begin
            next_act = 1'b1;
            next_tick = 19'h00000;
            next_left = units_in;
        end else if (act) begin
            if (tick == 19'(TICK - 1)) begin
                next_tick = 19'h00000;
                next_left = left - 14'h0001;
                if (left <= 14'h0001) begin
                    next_act = 1'b0;
                end
            end else begin
                next_tick = tick + 19'h00001;
            end
        end
    end

    // timer state
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            act <= 1'b0;
            tick <= 19'h00000;
            left <= 14'h0000;
        end else begin
            act <= next_act;
            tick <= next_tick;
            left <= next_left;
        end
    end

    assign active_out = act;
endmodule
`default_nettype wire

// ### mpc_core.sv
`timescale 1ns/1ps
`default_nettype none
module mpc_core #(
    parameter int TICK_CYC = mpc_pkg::TICK_CYC,
    parameter int FILT_SLOW = mpc_pkg::FILT_SLOW,
    parameter int FILT_FAST = mpc_pkg::FILT_FAST
) (
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic count_input_a_in,
    input wire logic count_input_b_in,
    input wire logic reset_one_in,
    input wire logic reset_two_in,
    input wire logic reset_key_in,
    input wire mpc_pkg::mpc_cfg_t config_in,
    input wire mpc_pkg::mpc_omode_t out_mode_in,
    input wire logic six_digit_in,
    input wire logic fast_speed_in,
    input wire logic disp_aux_in,
    input wire logic dual_sub_in,
    input wire logic sub_mode_ok_in,
    input wire logic [19:0] set_one_in,
    input wire logic [19:0] set_two_in,
    input wire logic [19:0] batch_set_in,
    input wire logic signed [21:0] dual_set_in,
    input wire logic [13:0] shot_time_in,
    input wire logic restore_in,
    input wire logic restore_one_in,
    input wire logic restore_two_in,
    output logic output_stage_one_out,
    output logic output_stage_two_out,
    output logic [19:0] channel_a_present_value_out,
    output logic [19:0] channel_b_present_value_out,
    output logic signed [20:0] total_out,
    output logic [19:0] batch_count_out,
    output logic signed [21:0] dual_value_out,
    output logic overflow_out
);
    logic [3:0] pins, lvl, rise;
    logic [19:0] pv, pvb, bat, fs, sv1, sv2;
    logic signed [20:0] tot, neg;
    logic signed [21:0] dv;
    logic bhold, hold1, hold2, ovf, output_stage_one, output_stage_two, shot1, shot2;
    logic [19:0] next_pv, next_pvb, next_bat;
    logic signed [20:0] next_tot;
    logic signed [21:0] next_dv;
    logic next_bhold, next_hold1, next_hold2, next_ovf, next_output_stage_one, next_output_stage_two;
    logic ra, rb, up, dn, key, use_sub, r1, r2, lv1, lv2;
    logic st1, st2, sp1, sp2, clr1, clr2;
    logic [13:0] units;

    // pins: a, b, reset one, reset two; resets always use the fast filter
    assign pins = {reset_two_in, reset_one_in, count_input_b_in,
        count_input_a_in};
    for (genvar i = 0; i < 4; i++) begin : g_in
        mpc_in_filter #(
            .SLOW(FILT_SLOW),
            .FAST(FILT_FAST)
        ) u_flt (
            .sys_clk_in(sys_clk_in),
            .reset_in(reset_in),
            .pin_in(pins[i]),
            .fast_in(fast_speed_in | (i >= 2)),
            .level_out(lvl[i]),
            .rise_out(rise[i])
        );
    end

    // one-shot timers, one per stage
    mpc_pulse_timer #(.TICK(TICK_CYC)) u_shot1 (
        .sys_clk_in(sys_clk_in),
        .reset_in(reset_in),
        .start_in(st1),
        .stop_in(sp1),
        .units_in(units),
        .active_out(shot1)
    );
    mpc_pulse_timer #(.TICK(TICK_CYC)) u_shot2 (
        .sys_clk_in(sys_clk_in),
        .reset_in(reset_in),
        .start_in(st2),
        .stop_in(sp2),
        .units_in(units),
        .active_out(shot2)
    );

    // limits, clamped set values and decoded events
    always_comb begin
        fs = six_digit_in ? mpc_pkg::FS_SIX : mpc_pkg::FS_FOUR;
        neg = six_digit_in ? mpc_pkg::NEG_SIX : mpc_pkg::NEG_FOUR;
        sv1 = (set_one_in > fs) ? fs : set_one_in;
        sv2 = (set_two_in > fs) ? fs : set_two_in;
        units = shot_time_in;
        if (shot_time_in < mpc_pkg::SHOT_MIN) begin
            units = mpc_pkg::SHOT_MIN;
        end else if (shot_time_in > mpc_pkg::SHOT_MAX) begin
            units = mpc_pkg::SHOT_MAX;
        end
        ra = lvl[2];
        rb = lvl[3];
        up = rise[0] & ~rise[1];
        dn = rise[1] & ~rise[0];
        key = reset_key_in;
        use_sub = dual_sub_in & six_digit_in & sub_mode_ok_in;
    end

    // counters, completion and outputs
    always_comb begin
        next_pv = pv;
        next_pvb = pvb;
        next_tot = tot;
        next_bat = bat;
        next_ovf = ovf;
        next_bhold = bhold;
        clr1 = 1'b0;
        clr2 = 1'b0;
        unique case (config_in)
            mpc_pkg::MPC_DUAL: begin
                // both inputs count up into their own channel
                if (!ovf) begin
                    if (ra) begin
                        next_pv = 20'h00000;
                    end else if (rise[0]) begin
                        if (pv == fs) next_ovf = 1'b1;
                        else next_pv = pv + 20'h00001;
                    end
                    if (rb) begin
                        next_pvb = 20'h00000;
                    end else if (rise[1]) begin
                        if (pvb == fs) next_ovf = 1'b1;
                        else next_pvb = pvb + 20'h00001;
                    end
                end
                if (key) begin
                    next_pv = 20'h00000;
                    next_pvb = 20'h00000;
                    next_ovf = 1'b0;
                    clr1 = 1'b1;
                    clr2 = 1'b1;
                end
            end
            mpc_pkg::MPC_TWIN: begin
                // independent up counters, key clears shown one
                if (ra) next_pv = 20'h00000;
                else if (rise[0]) next_pv = (pv == fs) ? 20'h00000 :
                    pv + 20'h00001;
                if (rb) next_pvb = 20'h00000;
                else if (rise[1]) next_pvb = (pvb == fs) ? 20'h00000 :
                    pvb + 20'h00001;
                clr1 = ra | (key & ~disp_aux_in);
                clr2 = rb | (key & disp_aux_in);
                if (key & ~disp_aux_in) next_pv = 20'h00000;
                if (key & disp_aux_in) next_pvb = 20'h00000;
            end
            default: begin
                // up on input a, down on input b, blocked in reset one
                if (ra) begin
                    next_pv = 20'h00000;
                end else if (up) begin
                    next_pv = (pv == fs) ? 20'h00000 : pv + 20'h00001;
                end else if (dn) begin
                    next_pv = (pv == 20'h00000) ? fs : pv - 20'h00001;
                end
                clr1 = ra | key;
                clr2 = ra | key;
                if (config_in == mpc_pkg::MPC_TOTAL) begin
                    // total runs on regardless of present resets
                    if (rb) begin
                        next_tot = 21'sh000000;
                    end else if (up) begin
                        next_tot = (tot == $signed({1'b0, fs})) ? 21'sh000000
                            : tot + 21'sh000001;
                    end else if (dn) begin
                        next_tot = (tot == -neg) ? 21'sh000000
                            : tot - 21'sh000001;
                    end
                    if (key) next_pv = 20'h00000;
                    if (key & disp_aux_in) next_tot = 21'sh000000;
                end
                if (key) next_pv = 20'h00000;
            end
        endcase
        // completion events on reaching a set value
        r1 = (next_pv != pv) & (next_pv == sv1);
        r2 = (next_pv != pv) & (next_pv == sv2);
        lv1 = next_pv >= sv1;
        lv2 = next_pv >= sv2;
        next_dv = use_sub ? $signed({2'b00, next_pv}) - $signed({2'b00, next_pvb})
            : $signed({2'b00, next_pv}) + $signed({2'b00, next_pvb});
        unique case (config_in)
            mpc_pkg::MPC_PRESET2: begin
            end
            mpc_pkg::MPC_TWIN: begin
                r2 = (next_pvb != pvb) & (next_pvb == sv2);
                lv2 = next_pvb >= sv2;
            end
            mpc_pkg::MPC_DUAL: begin
                r2 = (next_dv != dv) & (next_dv == dual_set_in);
                lv2 = next_dv >= dual_set_in;
                r1 = r2;
                lv1 = lv2;
            end
            default: begin
                r1 = r2;
                lv1 = lv2;
            end
        endcase
        // batch count and its latched output
        if (config_in == mpc_pkg::MPC_BATCH) begin
            if (rb) begin
                next_bat = 20'h00000;
            end else if (r2) begin
                next_bat = (bat == fs) ? 20'h00000 : bat + 20'h00001;
            end
            if (key & disp_aux_in) begin
                next_bat = 20'h00000;
            end
            next_bhold = (batch_set_in != 20'h00000 && next_bat >= batch_set_in)
                | (restore_in & restore_one_in)
                | (bhold & ~rb & ~(key & disp_aux_in));
            clr1 = 1'b1;
            r1 = 1'b0;
        end else begin
            next_bhold = 1'b0;
        end
        // hold latches: set wins over clear
        next_hold1 = r1 | (restore_in & restore_one_in) | (hold1 & ~clr1);
        next_hold2 = r2 | (restore_in & restore_two_in) | (hold2 & ~clr2);
        st1 = (out_mode_in == mpc_pkg::MPC_ONESHOT)
            & (r1 | (restore_in & restore_one_in));
        st2 = (out_mode_in == mpc_pkg::MPC_ONESHOT)
            & (r2 | (restore_in & restore_two_in));
        sp1 = clr1;
        sp2 = clr2;
        unique case (out_mode_in)
            mpc_pkg::MPC_HOLD: begin
                next_output_stage_one = next_hold1;
                next_output_stage_two = next_hold2;
            end
            mpc_pkg::MPC_INSTANT: begin
                next_output_stage_one = lv1 & ~clr1;
                next_output_stage_two = lv2 & ~clr2;
            end
            default: begin
                next_output_stage_one = shot1;
                next_output_stage_two = shot2;
            end
        endcase
        if (config_in == mpc_pkg::MPC_BATCH) next_output_stage_one = next_bhold;
        if (config_in == mpc_pkg::MPC_PRESET1 || config_in == mpc_pkg::MPC_TOTAL
            || config_in == mpc_pkg::MPC_DUAL) next_output_stage_one = next_output_stage_two;
    end

    // counting state and output registers
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            pv <= 20'h00000;
            pvb <= 20'h00000;
            tot <= 21'sh000000;
            bat <= 20'h00000;
            dv <= 22'sh000000;
            bhold <= 1'b0;
            hold1 <= 1'b0;
            hold2 <= 1'b0;
            ovf <= 1'b0;
            output_stage_one <= 1'b0;
            output_stage_two <= 1'b0;
        end else begin
            pv <= next_pv;
            pvb <= next_pvb;
            tot <= next_tot;
            bat <= next_bat;
            dv <= next_dv;
            bhold <= next_bhold;
            hold1 <= next_hold1;
            hold2 <= next_hold2;
            ovf <= next_ovf;
            output_stage_one <= next_output_stage_one;
            output_stage_two <= next_output_stage_two;
        end
    end

    assign output_stage_one_out = output_stage_one;
    assign output_stage_two_out = output_stage_two;
    assign channel_a_present_value_out = pv;
    assign channel_b_present_value_out = pvb;
    assign total_out = tot;
    assign batch_count_out = bat;
    assign dual_value_out = dv;
    assign overflow_out = ovf;

    // checks
    sequence s_batch_over;
        config_in == mpc_pkg::MPC_BATCH && batch_set_in != 20'h00000
            && next_bat >= batch_set_in;
    endsequence
    property p_reset_blocks;
        @(posedge sys_clk_in) disable iff (reset_in)
        config_in == mpc_pkg::MPC_PRESET2 && ra |=> pv == 20'h00000;
    endproperty
    a_reset_blocks: assert property (p_reset_blocks) else $error("count in reset");
    property p_same_out;
        @(posedge sys_clk_in) disable iff (reset_in)
        config_in == mpc_pkg::MPC_PRESET1 && $stable(config_in) |=> output_stage_one == output_stage_two;
    endproperty
    a_same_out: assert property (p_same_out) else $error("outputs differ");
    property p_wrap;
        @(posedge sys_clk_in) disable iff (reset_in)
        config_in == mpc_pkg::MPC_PRESET2 && !ra && !key && up && pv == fs
            |=> pv == 20'h00000;
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap at full scale");
    property p_shot_end;
        @(posedge sys_clk_in) disable iff (reset_in)
        config_in == mpc_pkg::MPC_PRESET2 && shot1 && ra |=> !shot1 ##1 !output_stage_one
            || out_mode_in != mpc_pkg::MPC_ONESHOT;
    endproperty
    a_shot_end: assert property (p_shot_end) else $error("pulse kept");
    property p_total_runs;
        @(posedge sys_clk_in) disable iff (reset_in)
        config_in == mpc_pkg::MPC_TOTAL && ra && up && !rb && !key
            && tot >= 21'sh000000 && tot < $signed({1'b0, fs})
            |=> tot == $past(tot) + 21'sh000001;
    endproperty
    a_total_runs: assert property (p_total_runs) else $error("total stalled");
    property p_batch_zero;
        @(posedge sys_clk_in) disable iff (reset_in)
        config_in == mpc_pkg::MPC_BATCH && rb |=> bat == 20'h00000;
    endproperty
    a_batch_zero: assert property (p_batch_zero) else $error("batch not held");
    property p_batch_latch;
        @(posedge sys_clk_in) disable iff (reset_in)
        s_batch_over |=> (bhold && output_stage_one) || $changed(config_in);
    endproperty
    a_batch_latch: assert property (p_batch_latch) else $error("batch out low");
    property p_ovf_stop;
        @(posedge sys_clk_in) disable iff (reset_in)
        config_in == mpc_pkg::MPC_DUAL && ovf && !key
            |=> $stable(pv) && $stable(pvb) && ovf;
    endproperty
    a_ovf_stop: assert property (p_ovf_stop) else $error("count after overflow");
endmodule
`default_nettype wire

// ### mpc_pulse_src.sv
`timescale 1ns/1ps
`default_nettype none
module mpc_pulse_src (
    input wire logic sys_clk_in,
    output var logic count_a_out,
    output var logic count_b_out,
    output var logic rst_one_out,
    output var logic rst_two_out
);
    // sensors idle low, switches open
    initial begin
        count_a_out = 1'b0;
        count_b_out = 1'b0;
        rst_one_out = 1'b0;
        rst_two_out = 1'b0;
    end

    // n sensor pulses, high and low each held w cycles
    task automatic pulse(input bit on_a, input bit on_b, input int n,
                         input int w);
        for (int i = 0; i < n; i++) begin
            @(negedge sys_clk_in);
            count_a_out = on_a;
            count_b_out = on_b;
            repeat (w) @(negedge sys_clk_in);
            count_a_out = 1'b0;
            count_b_out = 1'b0;
            repeat (w - 1) @(negedge sys_clk_in);
        end
    endtask

    // reset switch levels, changed at the falling edge
    task automatic sw(input bit two, input bit v);
        @(negedge sys_clk_in);
        if (two) rst_two_out = v;
        else rst_one_out = v;
    endtask
endmodule
`default_nettype wire

// ### tb_multimode_preset_counter_core.sv
`timescale 1ns/1ps
`default_nettype none
module tb_multimode_preset_counter_core;
    typedef struct {
        mpc_pkg::mpc_cfg_t cfg; mpc_pkg::mpc_omode_t md; logic six;
        logic [19:0] sv; int na; int nb;
        logic [19:0] ea; logic [19:0] eb; logic [1:0] eo; bit co;
    } mpc_row_t;
    logic sys_clk_in = 1'b0, reset_in = 1'b1, key = 1'b0, six = 1'b0;
    logic aux = 1'b0, sub = 1'b0, sub_ok = 1'b0, rs = 1'b0, r1 = 1'b0;
    logic r2 = 1'b0, ca, cb, ro, rt, o1, o2, ovf;
    mpc_pkg::mpc_cfg_t cfg = mpc_pkg::MPC_PRESET1;
    mpc_pkg::mpc_omode_t md = mpc_pkg::MPC_HOLD;
    logic [19:0] sv = 20'h00000, bset = 20'h00000, pa, pb, bc;
    logic signed [21:0] dset = 22'sh000064;
    logic [13:0] shot = 14'h0003;
    logic signed [20:0] tot;
    logic signed [21:0] dv;
    int err_total = 0, n_tests = 0, cnt;
    mpc_row_t rows[7] = '{
        '{mpc_pkg::MPC_PRESET1, mpc_pkg::MPC_HOLD, 1'b0, 20'h00003, 3, 0,
          20'h00003, 20'h00000, 2'h3, 1'b1},
        '{mpc_pkg::MPC_PRESET1, mpc_pkg::MPC_INSTANT, 1'b0, 20'h00005, 3, 0,
          20'h00003, 20'h00000, 2'h0, 1'b1},
        '{mpc_pkg::MPC_PRESET2, mpc_pkg::MPC_HOLD, 1'b0, 20'h01388, 0, 1,
          mpc_pkg::FS_FOUR, 20'h00000, 2'h0, 1'b0},
        '{mpc_pkg::MPC_PRESET1, mpc_pkg::MPC_HOLD, 1'b1, 20'h01388, 0, 1,
          mpc_pkg::FS_SIX, 20'h00000, 2'h0, 1'b0},
        '{mpc_pkg::MPC_TOTAL, mpc_pkg::MPC_INSTANT, 1'b0, 20'h00001, 2, 1,
          20'h00001, 20'h00000, 2'h3, 1'b1},
        '{mpc_pkg::MPC_DUAL, mpc_pkg::MPC_HOLD, 1'b0, 20'h00009, 2, 3,
          20'h00002, 20'h00003, 2'h0, 1'b1},
        '{mpc_pkg::MPC_TWIN, mpc_pkg::MPC_HOLD, 1'b0, 20'h00009, 2, 1,
          20'h00002, 20'h00001, 2'h0, 1'b1}};

    always #12.5 sys_clk_in = ~sys_clk_in;

    mpc_pulse_src src (.sys_clk_in(sys_clk_in), .count_a_out(ca),
        .count_b_out(cb), .rst_one_out(ro), .rst_two_out(rt));

    mpc_core #(.TICK_CYC(10), .FILT_SLOW(8), .FILT_FAST(4)) dut (
        .sys_clk_in(sys_clk_in), .reset_in(reset_in),
        .count_input_a_in(ca), .count_input_b_in(cb), .reset_one_in(ro),
        .reset_two_in(rt), .reset_key_in(key), .config_in(cfg),
        .out_mode_in(md), .six_digit_in(six), .fast_speed_in(1'b1),
        .disp_aux_in(aux), .dual_sub_in(sub), .sub_mode_ok_in(sub_ok),
        .set_one_in(sv), .set_two_in(sv), .batch_set_in(bset),
        .dual_set_in(dset), .shot_time_in(shot), .restore_in(rs),
        .restore_one_in(r1), .restore_two_in(r2),
        .output_stage_one_out(o1), .output_stage_two_out(o2),
        .channel_a_present_value_out(pa), .channel_b_present_value_out(pb),
        .total_out(tot), .batch_count_out(bc), .dual_value_out(dv),
        .overflow_out(ovf));

    // compare one value and count it
    task automatic chk(input logic [21:0] got, input logic [21:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask

    // settings applied with reset at the falling edge, reset held for two cycles
    task automatic start(input mpc_pkg::mpc_cfg_t c,
                         input mpc_pkg::mpc_omode_t m, input logic s,
                         input logic [19:0] v);
        @(negedge sys_clk_in);
        reset_in = 1'b1;
        cfg = c;
        md = m;
        six = s;
        sv = v;
        repeat (2) @(negedge sys_clk_in);
        reset_in = 1'b0;
        repeat (4) @(negedge sys_clk_in);
    endtask

    // one-cycle pulse on the key or restore input
    task automatic tap(input bit restore);
        @(negedge sys_clk_in);
        if (restore) rs = 1'b1;
        else key = 1'b1;
        @(negedge sys_clk_in);
        rs = 1'b0;
        key = 1'b0;
        repeat (3) @(negedge sys_clk_in);
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // watchdog, well above the expected run of about 1000 cycles
    initial begin
        #1_000_000;
        err_total++;
        give_verdict();
    end

    initial begin
        repeat (2) @(negedge sys_clk_in);
        chk({20'h00000, o1, o2}, 22'h0);
        chk(pa, 20'h00000);
        foreach (rows[i]) begin
            start(rows[i].cfg, rows[i].md, rows[i].six, rows[i].sv);
            src.pulse(1, 0, rows[i].na, 8);
            src.pulse(0, 1, rows[i].nb, 8);
            repeat (16) @(negedge sys_clk_in);
            chk(pa, rows[i].ea);
            if (rows[i].cfg >= mpc_pkg::MPC_DUAL) chk(pb, rows[i].eb);
            if (rows[i].co) chk({o1, o2}, rows[i].eo);
            if (rows[i].cfg == mpc_pkg::MPC_DUAL) chk(dv, 22'h000005);
            $display("row %0d done", i);
        end
        // total survives present resets, cleared by reset two and key
        start(mpc_pkg::MPC_TOTAL, mpc_pkg::MPC_HOLD, 1'b0, 20'h00064);
        src.pulse(1, 0, 3, 8);
        src.sw(0, 1);
        src.pulse(1, 0, 2, 8);
        chk(pa, 20'h00000);
        src.sw(0, 0);
        src.pulse(1, 0, 2, 8);
        repeat (16) @(negedge sys_clk_in);
        chk(pa, 20'h00002);
        chk({tot[20], tot}, 22'h000007);
        src.sw(1, 1);
        repeat (8) @(negedge sys_clk_in);
        src.sw(1, 0);
        repeat (12) @(negedge sys_clk_in);
        chk({tot[20], tot}, 22'h000000);
        src.pulse(1, 0, 1, 8);
        aux = 1'b1;
        tap(0);
        aux = 1'b0;
        chk({tot[20], tot}, 22'h000000);
        chk(pa, 20'h00000);
        $display("total test done");
        // batch counting with zero batch set value
        start(mpc_pkg::MPC_BATCH, mpc_pkg::MPC_HOLD, 1'b0, 20'h00002);
        src.pulse(1, 0, 3, 8);
        repeat (16) @(negedge sys_clk_in);
        chk(bc, 20'h00001);
        chk(o1, 1'b0);
        src.sw(1, 1);
        repeat (12) @(negedge sys_clk_in);
        chk(bc, 20'h00000);
        src.sw(1, 0);
        // batch output latches, survives a raised set, cleared by reset two
        bset = 20'h00001;
        start(mpc_pkg::MPC_BATCH, mpc_pkg::MPC_HOLD, 1'b0, 20'h00002);
        src.pulse(1, 0, 2, 8);
        repeat (16) @(negedge sys_clk_in);
        chk(o1, 1'b1);
        bset = 20'h00005;
        repeat (4) @(negedge sys_clk_in);
        chk(o1, 1'b1);
        src.sw(1, 1);
        repeat (12) @(negedge sys_clk_in);
        chk({o1, bc}, 21'h000000);
        src.sw(1, 0);
        bset = 20'h00000;
        $display("batch test done");
        // dual subtraction and per-channel reset
        start(mpc_pkg::MPC_DUAL, mpc_pkg::MPC_HOLD, 1'b1, 20'h00009);
        sub = 1'b1;
        sub_ok = 1'b1;
        src.pulse(1, 0, 2, 8);
        src.pulse(0, 1, 3, 8);
        repeat (16) @(negedge sys_clk_in);
        chk(dv, 22'h3FFFFF);
        src.sw(0, 1);
        src.pulse(0, 1, 1, 8);
        repeat (16) @(negedge sys_clk_in);
        chk({pa, pb}, {20'h00000, 20'h00004});
        chk(dv, 22'h3FFFFC);
        src.sw(0, 0);
        sub = 1'b0;
        $display("dual test done");
        // one-shot length, then cut short by reset one
        start(mpc_pkg::MPC_PRESET1, mpc_pkg::MPC_ONESHOT, 1'b0, 20'h00001);
        fork
            src.pulse(1, 0, 1, 8);
        join_none
        cnt = 0;
        while (o1 !== 1'b1 && cnt < 100) begin
            @(negedge sys_clk_in);
            cnt++;
        end
        cnt = 0;
        while (o1 === 1'b1 && cnt < 100) begin
            @(negedge sys_clk_in);
            cnt++;
        end
        chk(22'(cnt), 22'h00001E);
        shot = 14'h0064;
        start(mpc_pkg::MPC_PRESET2, mpc_pkg::MPC_ONESHOT, 1'b0, 20'h00001);
        src.pulse(1, 0, 1, 8);
        repeat (8) @(negedge sys_clk_in);
        chk(o1, 1'b1);
        src.sw(0, 1);
        repeat (12) @(negedge sys_clk_in);
        chk(o1, 1'b0);
        src.sw(0, 0);
        $display("one-shot test done");
        // outputs come back after power recovery
        start(mpc_pkg::MPC_PRESET1, mpc_pkg::MPC_HOLD, 1'b0, 20'h00009);
        r1 = 1'b1;
        r2 = 1'b1;
        tap(1);
        chk({o1, o2}, 2'h3);
        $display("restore test done");
        give_verdict();
    end
endmodule
`default_nettype wire
